// [rtl/ram_partition.sv]
`timescale 1ns/100ps
`include "ram_part_regs.svh"
module ram_partition #(
    parameter logic [31:0] RAM_SIZE = `DATA_RAM_SIZE_DEFAULT
) (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output ram_part_pkg::bounds_t    bounds
);
    import ram_part_pkg::*;

    ahb_req_t      req;            // address phase as one bundle
    access_state_t state;          // kind of the data phase under way
    access_state_t next_state;
    logic [7:0]    addr_q;         // offset held through the data phase
    logic [7:0]    next_addr;
    logic [3:0]    slot_q;         // one-hot register slot of addr_q
    logic [3:0]    next_slot;
    logic          taken;          // address phase accepted at this edge
    logic          read_phase;
    logic          write_phase;
    logic [2:0]    base_write;     // one strobe per boundary field
    logic          forward_hit;
    logic [31:0]   forward_word;
    logic [31:0]   next_rdata;
    logic [31:0]   kp_value;
    logic [31:0]   ud_value;
    logic [31:0]   up_value;

    // exact match on the decoded low address byte; higher bits alias
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // one-hot slot of an offset: bit 0 kernel program, bit 1 user data,
    // bit 2 user program, bit 3 size; holes give zero and read zero
    function automatic logic [3:0] slot_of(input logic [7:0] a);
        slot_of = {hit(a, `DATA_RAM_SIZE_OFFSET),
                   hit(a, `USER_PROGRAM_BASE_OFFSET),
                   hit(a, `USER_DATA_BASE_OFFSET),
                   hit(a, `KERNEL_PROGRAM_BASE_OFFSET)};
    endfunction

    // bus word of a boundary field; nothing is stored around the field
    function automatic logic [31:0] base_word(input logic [5:0] f);
        base_word = {16'h0000, f, 10'h000};
    endfunction

    // bundle the address phase so the decode reads one carrier
    assign req = '{htrans: htrans, haddr: haddr, hwrite: hwrite,
                   hsize: hsize, hsel: hsel, hready: hready};

    // an address phase counts only when selected, ready and non-idle;
    // busy and idle transfers leave nothing for the data phase
    assign taken = req.hready && req.hsel && req.htrans[1];

    // next data-phase kind, offset and slot; while another slave stalls
    // the bus the current data phase simply goes on
    always_comb begin
        next_state = state;
        next_addr  = addr_q;
        next_slot  = slot_q;
        if (req.hready) begin
            next_addr  = req.haddr[7:0];
            next_slot  = slot_of(req.haddr[7:0]);
            next_state = reg_none;
            if (taken) begin
                next_state = req.hwrite ? reg_write : reg_read;
            end
        end
    end

    // decode the one-hot state into the two phase flags
    always_comb begin
        read_phase  = 1'b0;
        write_phase = 1'b0;
        case (state)
            reg_none: begin
                read_phase  = 1'b0;
                write_phase = 1'b0;
            end
            reg_read: begin
                read_phase  = 1'b1;
            end
            reg_write: begin
                write_phase = 1'b1;
            end
            default: begin
                read_phase  = 1'b0;
                write_phase = 1'b0;
            end
        endcase
    end

    // kind of the data phase; reset leaves the bus with nothing pending
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= reg_none;
        end else begin
            state <= next_state;
        end
    end

    // offset of the transfer in its data phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_q <= 8'h00;
        end else begin
            addr_q <= next_addr;
        end
    end

    // slot of the transfer in its data phase, decoded once up front
    // so the write strobes do not sit behind the comparators
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slot_q <= 4'h0;
        end else begin
            slot_q <= next_slot;
        end
    end

    // a write lands at the edge that ends its data phase; the size slot
    // has no strobe at all, so writes to it vanish
    assign base_write = {3{write_phase && req.hready}} & slot_q[2:0];

    // kernel program base: same format, used only as the lower bound
    base_field kernel_program_field (
        .clock        (clock),
        .resetn       (resetn),
        .write_strobe (base_write[0]),
        .write_data   (hwdata),
        .field        (bounds.kernel_program),
        .read_value   (kp_value)
    );

    // user data base
    base_field user_data_field (
        .clock        (clock),
        .resetn       (resetn),
        .write_strobe (base_write[1]),
        .write_data   (hwdata),
        .field        (bounds.user_data),
        .read_value   (ud_value)
    );

    // user program base
    base_field user_program_field (
        .clock        (clock),
        .resetn       (resetn),
        .write_strobe (base_write[2]),
        .write_data   (hwdata),
        .field        (bounds.user_program),
        .read_value   (up_value)
    );

    // ordering and size limits are software's duty: bad values are
    // stored as written, and the decode that uses them must cope

    // a write in its data phase lands at the same edge that takes the
    // next address phase; forward it so a read right behind it is fresh
    assign forward_hit  = write_phase && req.hready &&
                          (slot_q[2:0] != 3'b000) &&
                          (next_addr == addr_q);
    assign forward_word = base_word(hwdata[`BASE_FIELD_MSB:`BASE_FIELD_LSB]);

    // word for the coming data phase; zero whenever no read is under way
    always_comb begin
        next_rdata = hrdata;
        if (req.hready) begin
            next_rdata = 32'h00000000;
            if (taken && !req.hwrite) begin
                case (next_slot)
                    4'b0001: next_rdata = kp_value;
                    4'b0010: next_rdata = ud_value;
                    4'b0100: next_rdata = up_value;
                    4'b1000: next_rdata = RAM_SIZE;
                    default: next_rdata = 32'h00000000;
                endcase
                if (forward_hit) begin
                    next_rdata = forward_word;
                end
            end
        end
    end

    // read data from a register: costs no wait state, since the word is
    // chosen during the address phase and launched at its closing edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h00000000;
        end else begin
            hrdata <= next_rdata;
        end
    end

    // every access finishes at once and always with OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read_phase is kept for the decode symmetry; hrdata already
    // carries the read, so nothing else needs it
endmodule // ram_partition

// [common/ram_part_regs.svh]
// What this block does
// - upper sixteen bits of all three base registers read zero, no storage.
// - user data base keeps a writable field in bits 15 to 10.
// - user program base keeps a writable field in bits 15 to 10.
// - bits 9 to 0 of each base register always read zero.
// - reset clears every base register, giving all RAM to kernel data.
// - a fixed 32-bit read-only register reports RAM capacity in bytes.
// - size reads 0x1000, 0x2000, 0x4000, 0x8000 or 0x10000 by capacity.
// - kernel program base keeps a writable field in bits 15 to 10.
`ifndef RAM_PART_REGS_SVH
`define RAM_PART_REGS_SVH
`define KERNEL_PROGRAM_BASE_OFFSET 8'h00
`define USER_DATA_BASE_OFFSET      8'h04
`define USER_PROGRAM_BASE_OFFSET   8'h08
`define DATA_RAM_SIZE_OFFSET       8'h0C
`define BASE_FIELD_LSB             10
`define BASE_FIELD_MSB             15
`define BASE_FIELD_RESET           6'h00
`define DATA_RAM_SIZE_DEFAULT      32'h00010000
`endif

// [common/ram_part_pkg.sv]
package ram_part_pkg;
    typedef struct packed {
        logic [1:0]  htrans;
        logic [31:0] haddr;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hsel;
        logic        hready;
    } ahb_req_t;
    typedef enum logic [2:0] {
        reg_none = 3'b001,
        reg_read = 3'b010,
        reg_write = 3'b100
    } access_state_t;
    typedef struct packed {
        logic [5:0] kernel_program;
        logic [5:0] user_data;
        logic [5:0] user_program;
    } bounds_t;
endpackage

// [rtl/base_field.sv]
`timescale 1ns/100ps
`include "ram_part_regs.svh"
// one 1 KB-granular boundary field; only bits 15..10 have storage
module base_field (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        write_strobe,
    input  wire logic [31:0] write_data,
    output logic [5:0]       field,
    output logic [31:0]      read_value
);
    // reset gives all RAM to kernel data
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            field <= `BASE_FIELD_RESET;
        end else if (write_strobe) begin
            // low and upper bits of the write are dropped
            field <= write_data[`BASE_FIELD_MSB:`BASE_FIELD_LSB];
        end
    end
    // upper half and low ten bits are constant zero
    assign read_value = {16'h0000, field, 10'h000};
endmodule // base_field

// [verif/ram_part_assertions.sv]
`timescale 1ns/100ps
module ram_part_assertions #(
    parameter logic [31:0] RAM_SIZE = 32'h00010000
) (
    input wire logic                  clock, resetn, hsel, hwrite, hready,
    input wire logic [1:0]            htrans,
    input wire logic [31:0]           haddr, hwdata, hrdata,
    input wire logic                  hreadyout, hresp,
    input wire ram_part_pkg::bounds_t bounds
);
    import ram_part_pkg::*;
    logic [9:0] ph;                        // read, write, offset
    wire        tk = hsel & hready & htrans[1];
    // data-phase view; the address phase alone says nothing about data
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) ph <= 10'h000;
        else ph <= {tk & ~hwrite, tk & hwrite, haddr[7:0]};
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    okay_resp_a: assert property (hreadyout && !hresp) else $error("resp");
    hi_zero_a: assert property (ph[9] && ph[7:0] != 8'h0C |->
        hrdata[31:16] == 16'h0) else $error("high bits set");
    lo_zero_a: assert property (ph[9] && ph[7:0] != 8'h0C |->
        hrdata[9:0] == 10'h0) else $error("low bits set");
    size_value_a: assert property (ph[9] && ph[7:0] == 8'h0C |->
        hrdata == RAM_SIZE) else $error("size wrong");
    kprog_store_a: assert property (ph[8] && ph[7:0] == 8'h00 |=>
        bounds.kernel_program == $past(hwdata[15:10])) else $error("kp");
    udata_store_a: assert property (ph[8] && ph[7:0] == 8'h04 |=>
        bounds.user_data == $past(hwdata[15:10])) else $error("ud");
    uprog_store_a: assert property (ph[8] && ph[7:0] == 8'h08 |=>
        bounds.user_program == $past(hwdata[15:10])) else $error("up");
    reset_clear_a: assert property ($rose(resetn) |->
        bounds == 18'h0) else $error("reset value");
    cover property (ph[9] && ph[7:0] == 8'h0C);
    cover property (ph[8] && ph[7:0] == 8'h04);
    cover property (ph[8] && ph[7:0] == 8'h0C);
endmodule // ram_part_assertions

// [verif/tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
    import ram_part_pkg::*;
    localparam logic [31:0] SIZE = 32'h00004000;
    logic        clock, resetn, hsel, hwrite, rdy, hresp;
    logic [31:0] haddr, hwdata, hrdata, m [3];
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    bounds_t     bounds;
    int          err_count = 0, n_compared = 0, seed = 32'h50f65505;
    int          k, u, p;
    ram_partition #(.RAM_SIZE(SIZE)) u_dut (.clock, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(rdy), .hwdata, .hrdata,
        .hreadyout(rdy), .hresp, .bounds);
    // only bits 15..10 of a base survive; size and holes read fixed
    function automatic logic [31:0] exp_rd(logic [7:0] a);
        return a == 8'h0C ? SIZE : a > 8'h0C ? 32'h0 : m[a[3:2]];
    endfunction
    // one single AHB transfer, held until the slave says ready
    task automatic xfer(input logic w, input logic [7:0] a, logic [31:0] d);
        int n = 0;
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge clock); while (rdy !== 1'b1 && ++n < 99);
        // the previous write has landed by this edge
        `CHK("bounds", {m[0][15:10], m[1][15:10], m[2][15:10]}, bounds)
        {htrans, hwdata} <= {2'b00, d};
        do @(posedge clock); while (rdy !== 1'b1 && ++n < 99);
        if (!w) `CHK("read", exp_rd(a), hrdata)
        else if (a < 8'h0C) m[a[3:2]] = d & 32'h0000FC00;
    endtask
    // base write with random junk around the boundary field f
    task automatic put_base(input logic [7:0] a, input int f);
        xfer(1, a, ($random(seed) & 32'hFFFF03FF) | (32'(f) << 10));
    endtask
    task automatic do_reset;
        resetn <= 1'b0;
        m = '{default: '0};
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
    endtask
    task automatic print_verdict;
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard at 6000 cycles, four times the roughly 1500 cycles the run needs
    initial begin
        #60000;
        err_count++;
        print_verdict;
    end
    initial begin
        {resetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
        hsize = 3'b010;
        do_reset;
        for (int i = 0; i < 5; i++) xfer(0, 8'(4 * i), 0);
        // ones all around small ordered fields 1 < 2 < 3
        xfer(1, 8'h08, 32'hFFFF0FFF);
        xfer(1, 8'h04, 32'hFFFF0BFF);
        xfer(1, 8'h00, 32'hFFFF07FF);
        xfer(1, 8'h0C, '1);
        xfer(1, 8'h10, '1);
        for (int i = 0; i < 5; i++) xfer(0, 8'(4 * i), 0);
        for (int i = 0; i < 60; i++) begin
            k = {$random(seed)} % 14;
            u = k + 1 + {$random(seed)} % (15 - k);
            p = u + 1 + {$random(seed)} % (16 - u);
            // back to the reset split, then raise bounds top down
            for (int j = 0; j < 3; j++) put_base(8'(4 * j), 0);
            put_base(8'h08, p);
            put_base(8'h04, u);
            put_base(8'h00, k);
            xfer(0, 8'h00, 0);
            repeat (4) xfer(0, 8'(4 * ({$random(seed)} % 5)), 0);
            xfer(1, 8'(4 * (3 + {$random(seed)} % 2)), $random(seed));
        end
        do_reset;
        for (int i = 0; i < 4; i++) xfer(0, 8'(4 * i), 0);
        print_verdict;
    end
endmodule // tb
bind ram_partition ram_part_assertions #(.RAM_SIZE(RAM_SIZE)) u_chk (
    .clock, .resetn, .hsel, .hwrite, .hready, .htrans, .haddr, .hwdata,
    .hrdata, .hreadyout, .hresp, .bounds);
